// file: hdl/eewp_link.sv
// serial-clock side of the write-protect block: bit capture and status shift-out
// assumes status_snap is held still by the ref_clk side while chip select is low
module eewp_link (
    input  wire logic        spi_sck,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_si,
    input  wire logic [7:0]  status_snap,
    output logic [5:0]       frame_bits,
    output logic [15:0]      frame_word,
    output logic             so_o,
    output logic             so_oe
);

    logic        armed_q;
    logic [5:0]  cnt_q;
    logic [15:0] sh_q;
    logic [7:0]  out_q;
    logic [2:0]  obit_q;
    logic        rd_q;

    ////////////////////////////////////////////////////////////////////////////////
    // frame start marker, cleared while deselected
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= 1'b1;
        end
    end

    // bit count and input shifter, restarted on the first clock of a frame
    always_ff @(posedge spi_sck) begin
        if (!armed_q) begin
            cnt_q <= 6'h01;
            sh_q  <= {15'h0000, spi_si};
        end else begin
            sh_q <= {sh_q[14:0], spi_si};
            if (cnt_q != eewp_pkg::CNT_MAX) begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status shift-out on the falling edge, msb first, repeating
    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            rd_q   <= 1'b0;
            out_q  <= 8'h00;
            obit_q <= 3'h0;
        end else if (armed_q && !rd_q && cnt_q == eewp_pkg::CMD_BITS
                     && sh_q[7:0] == eewp_pkg::OP_STATUS_READ) begin
            rd_q   <= 1'b1;
            out_q  <= status_snap;
            obit_q <= 3'h0;
        end else if (rd_q) begin
            obit_q <= obit_q + 3'h1;
            if (obit_q == eewp_pkg::OUT_LAST_BIT) begin
                out_q <= status_snap;
            end else begin
                out_q <= {out_q[6:0], 1'b0};
            end
        end
    end

    assign so_o       = out_q[7];
    assign so_oe      = rd_q & ~spi_cs_n;
    assign frame_bits = cnt_q;
    assign frame_word = sh_q;

endmodule : eewp_link

// file: hdl/eewp_status_ctrl.sv
// write-protect and status control of a serial eeprom
// assumes a write engine on ref_clk and nonvolatile storage for three status bits
module eewp_status_ctrl #(
    parameter int ADDR_W = eewp_pkg::ADDR_W
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    input  wire logic              spi_sck,
    input  wire logic              spi_cs_n,
    input  wire logic              spi_si,
    input  wire logic              spi_wp_n,
    output logic                   spi_so_o,
    output logic                   spi_so_oe,
    input  wire logic [2:0]        nv_status_in,
    output logic [2:0]             nv_status_out,
    output logic                   nv_write_start,
    input  wire logic              array_write_req,
    input  wire logic [ADDR_W-1:0] array_write_addr,
    output logic                   array_write_grant,
    output logic                   array_write_refused,
    input  wire logic              write_busy,
    input  wire logic              write_done,
    output logic [7:0]             status_out,
    output logic                   hw_protect_active,
    output logic [2:0]             last_result
);

    eewp_pkg::eewp_state_t  state_q;
    eewp_pkg::eewp_state_t  state_d;
    eewp_pkg::eewp_result_t result_q;
    eewp_pkg::eewp_result_t result_d;

    logic        cs_s1_q;
    logic        cs_s2_q;
    logic        cs_s3_q;
    logic        wp_s1_q;
    logic        wp_s2_q;
    logic        frame_start;
    logic        frame_end;

    logic [5:0]  link_bits;
    logic [15:0] link_word;
    logic [5:0]  bits_q;
    logic [15:0] word_q;
    logic [7:0]  snap_q;

    logic        wel_q;
    logic        hpe_q;
    logic        bph_q;
    logic        bpl_q;
    logic        pending_q;
    logic        busy_any;
    logic        hw_prot;
    logic        commit;
    logic [7:0]  op;
    logic        is_set;
    logic        is_clr;
    logic        is_swr;
    logic        swr_ok;
    logic        prot_hit;
    logic        grant;
    logic        grant_q;
    logic        refused_q;
    logic        nv_start_q;
    logic [7:0]  status_q;
    logic [7:0]  status_d;

    ////////////////////////////////////////////////////////////////////////////////
    // serial-clock side
    eewp_link u_link (
        .spi_sck     (spi_sck),
        .spi_cs_n    (spi_cs_n),
        .spi_si      (spi_si),
        .status_snap (snap_q),
        .frame_bits  (link_bits),
        .frame_word  (link_word),
        .so_o        (spi_so_o),
        .so_oe       (spi_so_oe)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else if (clk_en) begin
            cs_s1_q <= spi_cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
        end else if (clk_en) begin
            wp_s1_q <= spi_wp_n;
            wp_s2_q <= wp_s1_q;
        end
    end

    assign frame_start = cs_s3_q & ~cs_s2_q;
    assign frame_end   = ~cs_s3_q & cs_s2_q;

    ////////////////////////////////////////////////////////////////////////////////
    // frame sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            eewp_pkg::EEWP_IDLE: begin
                if (frame_start) begin
                    state_d = eewp_pkg::EEWP_ACTIVE;
                end
            end
            eewp_pkg::EEWP_ACTIVE: begin
                if (frame_end) begin
                    state_d = eewp_pkg::EEWP_DECIDE;
                end
            end
            eewp_pkg::EEWP_DECIDE: begin
                state_d = eewp_pkg::EEWP_COMMIT;
            end
            eewp_pkg::EEWP_COMMIT: begin
                state_d = eewp_pkg::EEWP_IDLE;
            end
            default: begin
                state_d = eewp_pkg::EEWP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= eewp_pkg::EEWP_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // link words are still while the serial clock is parked after deselect
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bits_q <= 6'h00;
            word_q <= 16'h0000;
        end else if (clk_en && state_q == eewp_pkg::EEWP_DECIDE) begin
            bits_q <= link_bits;
            word_q <= link_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command decode at frame end
    assign commit = clk_en && state_q == eewp_pkg::EEWP_COMMIT;
    assign op     = (bits_q == eewp_pkg::CMD_BITS) ? word_q[7:0] : word_q[15:8];
    assign is_set = bits_q == eewp_pkg::CMD_BITS
                    && op == eewp_pkg::OP_LATCH_SET;
    assign is_clr = bits_q == eewp_pkg::CMD_BITS
                    && op == eewp_pkg::OP_LATCH_CLEAR;
    assign is_swr = bits_q == eewp_pkg::STATUS_WRITE_BITS
                    && op == eewp_pkg::OP_STATUS_WRITE;

    assign hw_prot  = ~wp_s2_q & hpe_q;
    assign busy_any = write_busy | pending_q;
    assign swr_ok   = commit & is_swr & wel_q & ~hw_prot
                      & ~busy_any;

    ////////////////////////////////////////////////////////////////////////////////
    // array protection check
    always_comb begin
        case ({bph_q, bpl_q})
            2'b00: begin
                prot_hit = 1'b0;
            end
            2'b01: begin
                prot_hit = array_write_addr >= eewp_pkg::PROT_Q_BASE
                           && array_write_addr <= eewp_pkg::ADDR_TOP;
            end
            2'b10: begin
                prot_hit = array_write_addr >= eewp_pkg::PROT_H_BASE
                           && array_write_addr <= eewp_pkg::ADDR_TOP;
            end
            2'b11: begin
                prot_hit = array_write_addr >= eewp_pkg::PROT_ALL_BASE;
            end
            default: begin
                prot_hit = 1'b1;
            end
        endcase
    end

    assign grant = clk_en & array_write_req & wel_q & ~prot_hit
                   & ~busy_any;

    ////////////////////////////////////////////////////////////////////////////////
    // write-enable latch
    // a set landing with a write completion wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wel_q <= eewp_pkg::WEL_RST;
        end else if (clk_en) begin
            if (commit && is_set) begin
                wel_q <= 1'b1;
            end else if ((commit && is_clr) || swr_ok || write_done) begin
                wel_q <= 1'b0;
            end
        end
    end

    // nonvolatile bits, restored from storage at reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hpe_q <= nv_status_in[2];
            bph_q <= nv_status_in[1];
            bpl_q <= nv_status_in[0];
        end else if (swr_ok) begin
            hpe_q <= word_q[eewp_pkg::ST_HPE_BIT];
            bph_q <= word_q[eewp_pkg::ST_BPH_BIT];
            bpl_q <= word_q[eewp_pkg::ST_BPL_BIT];
        end
    end

    // write cycle owned by this block until the engine reports completion
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pending_q <= 1'b0;
        end else if (clk_en) begin
            if (grant || swr_ok) begin
                pending_q <= 1'b1;
            end else if (write_done) begin
                pending_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // engine strobes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            grant_q    <= 1'b0;
            refused_q  <= 1'b0;
            nv_start_q <= 1'b0;
        end else if (clk_en) begin
            grant_q    <= grant;
            refused_q  <= array_write_req & ~grant;
            nv_start_q <= swr_ok;
        end
    end

    assign array_write_grant   = grant_q;
    assign array_write_refused = refused_q;
    assign nv_write_start      = nv_start_q;
    assign nv_status_out       = {hpe_q, bph_q, bpl_q};

    ////////////////////////////////////////////////////////////////////////////////
    // status value and frozen copy for the link
    // fields placed by position, spare bits zero
    always_comb begin
        status_d                        = {1'b0, eewp_pkg::ST_FILL, 4'h0};
        status_d[eewp_pkg::ST_HPE_BIT]  = hpe_q;
        status_d[eewp_pkg::ST_BPH_BIT]  = bph_q;
        status_d[eewp_pkg::ST_BPL_BIT]  = bpl_q;
        status_d[eewp_pkg::ST_WEL_BIT]  = wel_q;
        status_d[eewp_pkg::ST_BUSY_BIT] = busy_any;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_q <= 8'h00;
        end else if (clk_en) begin
            status_q <= status_d;
        end
    end

    // snapshot stops once select is seen low, so the link shifts a still word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            snap_q <= 8'h00;
        end else if (clk_en && state_q == eewp_pkg::EEWP_IDLE && cs_s2_q) begin
            snap_q <= status_q;
        end
    end

    assign status_out        = status_q;
    assign hw_protect_active = hw_prot;

    ////////////////////////////////////////////////////////////////////////////////
    // outcome of each completed frame; a status read leaves it unchanged
    // a refused status write reports busy ahead of lock
    always_comb begin
        result_d = result_q;
        if (commit) begin
            if (is_set || is_clr) begin
                result_d = eewp_pkg::EEWP_RES_DONE;
            end else if (is_swr && swr_ok) begin
                result_d = eewp_pkg::EEWP_RES_DONE;
            end else if (is_swr && busy_any) begin
                result_d = eewp_pkg::EEWP_RES_BUSY;
            end else if (is_swr) begin
                result_d = eewp_pkg::EEWP_RES_LOCKED;
            end else if (op != eewp_pkg::OP_STATUS_READ) begin
                result_d = eewp_pkg::EEWP_RES_LENGTH;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            result_q <= eewp_pkg::EEWP_RES_NONE;
        end else if (clk_en) begin
            result_q <= result_d;
        end
    end

    assign last_result = result_q;

endmodule : eewp_status_ctrl

// file: inc/eewp_pkg.sv
// constants for the eeprom write-protect and status block
// assumes an spi link on its own clock and a write engine on ref_clk
package eewp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // instruction opcodes, msb first on the serial input
    localparam logic [7:0] OP_LATCH_SET    = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;

    ////////////////////////////////////////////////////////////////////////////////
    // protection_status field positions
    localparam int ST_HPE_BIT  = 7;
    localparam int ST_BPH_BIT  = 3;
    localparam int ST_BPL_BIT  = 2;
    localparam int ST_WEL_BIT  = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam logic [2:0] ST_FILL = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and frame lengths
    localparam logic       WEL_RST           = 1'b0;
    localparam int         CNT_W             = 6;
    localparam logic [5:0] CMD_BITS          = 6'h08;
    localparam logic [5:0] STATUS_WRITE_BITS = 6'h10;
    localparam logic [5:0] CNT_MAX           = 6'h3f;
    localparam logic [2:0] OUT_LAST_BIT      = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // array protection bounds
    localparam int          ADDR_W        = 13;
    localparam logic [12:0] PROT_Q_BASE   = 13'h1800;
    localparam logic [12:0] PROT_H_BASE   = 13'h1000;
    localparam logic [12:0] PROT_ALL_BASE = 13'h0000;
    localparam logic [12:0] ADDR_TOP      = 13'h1fff;

    ////////////////////////////////////////////////////////////////////////////////
    // frame handling states
    typedef enum logic [3:0] {
        EEWP_IDLE   = 4'h1,
        EEWP_ACTIVE = 4'h2,
        EEWP_DECIDE = 4'h4,
        EEWP_COMMIT = 4'h8
    } eewp_state_t;

    // outcome of the last completed frame other than a status read
    typedef enum logic [2:0] {
        EEWP_RES_NONE   = 3'h0,
        EEWP_RES_DONE   = 3'h1,
        EEWP_RES_LENGTH = 3'h2,
        EEWP_RES_LOCKED = 3'h3,
        EEWP_RES_BUSY   = 3'h4
    } eewp_result_t;

endpackage : eewp_pkg

// file: test/eewp_chk.sv
// checker: write-protect and status relations at the block ports
// assumes bind onto eewp_status_ctrl; clk_en may be low for a while
module eewp_chk #(
    parameter int ADDR_W = 13
) (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic              clk_en,
    input wire logic              spi_cs_n,
    input wire logic              spi_wp_n,
    input wire logic              spi_so_oe,
    input wire logic [2:0]        nv_status_out,
    input wire logic              nv_write_start,
    input wire logic              array_write_req,
    input wire logic [ADDR_W-1:0] array_write_addr,
    input wire logic              array_write_grant,
    input wire logic              array_write_refused,
    input wire logic              write_busy,
    input wire logic              write_done,
    input wire logic [7:0]        status_out,
    input wire logic              hw_protect_active
);
    wire prot = (nv_status_out[1:0] == 2'h3) ||
        (nv_status_out[1:0] == 2'h2 && array_write_addr >= eewp_pkg::PROT_H_BASE) ||
        (nv_status_out[1:0] == 2'h1 && array_write_addr >= eewp_pkg::PROT_Q_BASE);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
////////////////////////////////////////////////////////////////////////////////
    property p_one;
        array_write_req && clk_en |=> array_write_grant != array_write_refused;
    endproperty
    a_one: assert property (p_one) else $error("array request answer");
    property p_wel; array_write_req && !status_out[1] |=> array_write_refused; endproperty
    a_wel: assert property (p_wel) else $error("grant without latch");
    property p_prot; array_write_req && prot |=> array_write_refused; endproperty
    a_prot: assert property (p_prot) else $error("protected block granted");
    property p_grant; array_write_grant |-> $past(array_write_req) && !$past(prot); endproperty
    a_grant: assert property (p_grant) else $error("grant without cause");
    property p_en_off; !nv_status_out[2] |-> !hw_protect_active; endproperty
    a_en_off: assert property (p_en_off) else $error("protect on with enable 0");
    property p_pin_hi; spi_wp_n [*3] |-> !hw_protect_active; endproperty
    a_pin_hi: assert property (p_pin_hi) else $error("protect on with pin high");
    property p_busy; write_busy |=> status_out[0]; endproperty
    a_busy: assert property (p_busy) else $error("busy flag missing");
    property p_done; write_done |-> ##2 !status_out[1]; endproperty
    a_done: assert property (p_done) else $error("latch kept after write");
    property p_nvs; nv_write_start |-> status_out[1]; endproperty
    a_nvs: assert property (p_nvs) else $error("status write without latch");
    property p_nv_hold;
        $changed(nv_status_out) |-> ($past(rst) || nv_write_start || $past(nv_write_start))
            or ##1 nv_write_start;
    endproperty
    a_nv_hold: assert property (p_nv_hold) else $error("status bits changed alone");
    property p_so_off; spi_cs_n [*2] |-> !spi_so_oe; endproperty
    a_so_off: assert property (p_so_off) else $error("output driven unselected");
    c_grant: cover property (array_write_grant);
    c_nvs: cover property (nv_write_start);
    c_hw: cover property (hw_protect_active);
endmodule : eewp_chk

bind eewp_status_ctrl eewp_chk #(.ADDR_W(ADDR_W)) i_eewp_chk (
    .ref_clk, .rst, .clk_en, .spi_cs_n, .spi_wp_n, .spi_so_oe, .nv_status_out,
    .nv_write_start, .array_write_req, .array_write_addr, .array_write_grant,
    .array_write_refused, .write_busy, .write_done, .status_out, .hw_protect_active
);

// file: test/eewp_host.sv
// host model: drives chip select, serial clock and serial data
// assumes the device samples on sck rise and shifts out on sck fall
module eewp_host (
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_si,
    input  wire logic spi_so_o,
    input  wire logic spi_so_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rd_q;
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b0;
        spi_si = 1'b0;
        rd_q = 8'h00;
        // a definite select rise clears the link state
        #1;
        spi_cs_n = 1'b1;
    end
////////////////////////////////////////////////////////////////////////////////
    // sends nbits of word msb first, captures bits after the first eight
    task automatic frame(input logic [15:0] word, input int nbits);
        #37.3;
        spi_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_si = word[15-i];
            #80;
            if (i >= 8) rd_q = {rd_q[6:0], spi_so_oe ? spi_so_o : 1'bx};
            spi_sck = 1'b1;
            #80;
            spi_sck = 1'b0;
        end
        #80;
        spi_cs_n = 1'b1;
        spi_si = ~spi_si;
        #320;
    endtask : frame
endmodule : eewp_host

// file: test/tb.sv
// testbench for the write-protect and status block
// assumes a host model on the link; bench acts as write engine and store
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk, rst, spi_sck, spi_cs_n, spi_si, spi_wp_n, spi_so_o, spi_so_oe;
    logic        nv_write_start, array_write_req, array_write_grant, array_write_refused;
    logic        write_busy, write_done, hw_protect_active, clk_en;
    logic [15:0] nv_starts;
    logic [2:0]  nv_status_in, nv_status_out, last_result;
    logic [12:0] array_write_addr;
    logic [7:0]  status_out;
    int          n_errors, samples_checked, cycles;
    eewp_status_ctrl i_eewp_status_ctrl (
        .ref_clk, .rst, .clk_en, .spi_sck, .spi_cs_n, .spi_si, .spi_wp_n,
        .spi_so_o, .spi_so_oe, .nv_status_in, .nv_status_out, .nv_write_start,
        .array_write_req, .array_write_addr, .array_write_grant, .array_write_refused,
        .write_busy, .write_done, .status_out, .hw_protect_active, .last_result
    );
    eewp_host i_eewp_host (.spi_sck, .spi_cs_n, .spi_si, .spi_so_o, .spi_so_oe);
    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;
////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    always @(posedge ref_clk) begin
        cycles++;
        if (nv_write_start === 1'b1) nv_starts++;
        if (cycles == 60000) begin
            n_errors++;
            results();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic cmd(input logic [7:0] op);
        i_eewp_host.frame({op, 8'h00}, 8);
    endtask : cmd
    task automatic status_write_cmd(input logic [7:0] d);
        i_eewp_host.frame({eewp_pkg::OP_STATUS_WRITE, d}, 16);
    endtask : status_write_cmd
    task automatic status_read_cmd(input logic [7:0] exp);
        i_eewp_host.frame({eewp_pkg::OP_STATUS_READ, 8'h00}, 16);
        chk(i_eewp_host.rd_q, exp, "status read");
    endtask : status_read_cmd
    task automatic done();
        cyc(1);
        write_done = 1'b1;
        cyc(1);
        write_done = 1'b0;
        cyc(3);
    endtask : done
    task automatic areq(input logic [12:0] a, input logic ok);
        cyc(1);
        array_write_addr = a;
        array_write_req = 1'b1;
        cyc(1);
        array_write_req = 1'b0;
        chk({array_write_grant, array_write_refused}, ok ? 2'b10 : 2'b01, "array answer");
    endtask : areq
    task automatic do_reset(input logic [2:0] nv);
        cyc(1);
        nv_status_in = nv;
        rst = 1'b1;
        cyc(5);
        rst = 1'b0;
        cyc(6);
    endtask : do_reset
////////////////////////////////////////////////////////////////////////////////
    task automatic t_latch();
        chk(status_out, 8'h00, "power-up status");
        chk(spi_so_oe, 1'b0, "output released");
        cmd(eewp_pkg::OP_LATCH_SET);
        chk(status_out, 8'h02, "latch set");
        status_read_cmd(8'h02);
        cmd(eewp_pkg::OP_LATCH_CLEAR);
        chk(status_out, 8'h00, "latch clear");
        i_eewp_host.frame({eewp_pkg::OP_LATCH_SET, 8'h00}, 9);
        chk(status_out, 8'h00, "nine-bit frame");
        i_eewp_host.frame({eewp_pkg::OP_LATCH_SET, 8'h8c}, 16);
        chk({nv_status_out, status_out}, 11'h000, "set run on");
        areq(13'h0000, 1'b0);
        $display("test latch done");
    endtask : t_latch
    task automatic t_freeze();
        cmd(eewp_pkg::OP_LATCH_SET);
        cyc(1);
        clk_en = 1'b0;
        cmd(eewp_pkg::OP_LATCH_CLEAR);
        cyc(1);
        array_write_req = 1'b1;
        cyc(1);
        array_write_req = 1'b0;
        chk({array_write_grant, array_write_refused}, 2'b00, "frozen answer");
        clk_en = 1'b1;
        write_busy = 1'b1;
        cyc(4);
        chk(status_out, 8'h03, "frozen frame lost");
        areq(13'h0000, 1'b0);
        write_busy = 1'b0;
        $display("test freeze done");
    endtask : t_freeze
    task automatic t_status();
        cmd(eewp_pkg::OP_LATCH_SET);
        status_write_cmd(8'hff);
        chk({nv_status_out, status_out}, 11'h78d, "status write");
        status_read_cmd(8'h8d);
        done();
        chk(status_out, 8'h8c, "after write");
        spi_wp_n = 1'b0;
        cyc(4);
        chk(hw_protect_active, 1'b1, "protect on");
        cmd(eewp_pkg::OP_LATCH_SET);
        chk(status_out, 8'h8e, "set under protect");
        status_write_cmd(8'h00);
        chk({nv_status_out, last_result}, 6'h3b, "locked write");
        cmd(eewp_pkg::OP_LATCH_CLEAR);
        chk(status_out, 8'h8c, "clear under protect");
        spi_wp_n = 1'b1;
        cyc(4);
        chk(hw_protect_active, 1'b0, "protect off");
        cmd(eewp_pkg::OP_LATCH_SET);
        status_write_cmd(8'h00);
        done();
        chk({nv_status_out, status_out}, 11'h000, "enable cleared");
        chk(nv_starts, 16'h0002, "status write starts");
        $display("test status done");
    endtask : t_status
    task automatic t_array();
        logic [13:0] lim [4];
        logic [12:0] adr [6];
        logic        ok;
        lim = '{14'h2000, 14'h1800, 14'h1000, 14'h0000};
        adr = '{13'h0000, 13'h0fff, 13'h1000, 13'h17ff, 13'h1800, 13'h1fff};
        for (int c = 0; c < 4; c++) begin
            cmd(eewp_pkg::OP_LATCH_SET);
            status_write_cmd({4'h0, c[1:0], 2'h0});
            done();
            cmd(eewp_pkg::OP_LATCH_SET);
            for (int j = 0; j < 6; j++) begin
                ok = {1'b0, adr[j]} < lim[c];
                areq(adr[j], ok);
                if (ok) begin
                    areq(adr[j], 1'b0);
                    write_busy = 1'b1;
                    cyc(2);
                    chk(status_out[0], 1'b1, "busy flag");
                    write_busy = 1'b0;
                    done();
                    chk(status_out[1], 1'b0, "latch after write");
                    cmd(eewp_pkg::OP_LATCH_SET);
                end
            end
        end
        $display("test array done");
    endtask : t_array
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        nv_starts = 16'h0000;
        spi_wp_n = 1'b1;
        nv_status_in = 3'h0;
        array_write_req = 1'b0;
        array_write_addr = 13'h0000;
        write_busy = 1'b0;
        write_done = 1'b0;
        do_reset(3'h0);
        t_latch();
        t_freeze();
        t_status();
        t_array();
        do_reset(3'h5);
        chk({nv_status_out, status_out}, 11'h584, "reload");
        $display("test reload done");
        results();
    end
endmodule : tb
